// ---- hw/sbc_code_decode.sv ----
// Combinational decoder from configuration word to buffer and block setting.
`timescale 1ns/10ps
`default_nettype none
module sbc_code_decode
  import sbc_pkg::*;
#(
  parameter int CHANNELS = SBC_CHANNELS  // Channels fitted on this build.
)(
  input  wire logic [15:0] cfg_word,    // Word offered by the host.
  sbc_cfg_if.src           dec,         // Decoded setting.
  output logic             fits_build   // Group lies inside this build.
);
  // Upper code and the group bases for each block size.
  wire [4:0] code    = cfg_word[SBC_CODE_MSB:SBC_CODE_LSB];
  wire [5:0] base_1  = cfg_word[5:0];
  wire [5:0] base_8  = {cfg_word[2:0], 3'b000};
  wire [5:0] base_16 = {cfg_word[2:1], 4'b0000};
  wire [5:0] base_32 = {cfg_word[2], 5'b00000};
  // Last channel plus one of the group, to compare with the build size.
  wire [7:0] grp_end = {2'b00, dec.first_chan} + {1'b0, dec.blk_chans};

  // Groups beyond the fitted channels are not valid on smaller builds.
  assign fits_build = (grp_end <= 8'(CHANNELS));

  // Table of the documented buffer and block combinations.
  always_comb
  begin
    dec.code_ok    = 1'b1;
    dec.buf_words  = SBC_BUF_64;
    dec.blk_chans  = SBC_BLK_1;
    dec.first_chan = 6'h00;
    case (code)
      SBC_C64_ONE:  begin dec.first_chan = base_1; end
      SBC_C64_G8:   begin dec.blk_chans = SBC_BLK_8; dec.first_chan = base_8; end
      SBC_C64_G16:  begin dec.blk_chans = SBC_BLK_16; dec.first_chan = base_16; end
      SBC_C64_G32:  begin dec.blk_chans = SBC_BLK_32; dec.first_chan = base_32; end
      SBC_C64_ALL:  begin dec.blk_chans = SBC_BLK_64; end
      SBC_C128_ONE: begin dec.buf_words = SBC_BUF_128; dec.first_chan = base_1; end
      SBC_C128_G8:
      begin
        dec.buf_words  = SBC_BUF_128;
        dec.blk_chans  = SBC_BLK_8;
        dec.first_chan = base_8;
      end
      SBC_C128_G16:
      begin
        dec.buf_words  = SBC_BUF_128;
        dec.blk_chans  = SBC_BLK_16;
        dec.first_chan = base_16;
      end
      SBC_C128_G32:
      begin
        dec.buf_words  = SBC_BUF_128;
        dec.blk_chans  = SBC_BLK_32;
        dec.first_chan = base_32;
      end
      SBC_C128_ALL: begin dec.buf_words = SBC_BUF_128; dec.blk_chans = SBC_BLK_64; end
      SBC_C256_ONE: begin dec.buf_words = SBC_BUF_256; dec.first_chan = base_1; end
      SBC_C256_G8:
      begin
        dec.buf_words  = SBC_BUF_256;
        dec.blk_chans  = SBC_BLK_8;
        dec.first_chan = base_8;
      end
      SBC_C256_G16:
      begin
        dec.buf_words  = SBC_BUF_256;
        dec.blk_chans  = SBC_BLK_16;
        dec.first_chan = base_16;
      end
      SBC_C256_G32:
      begin
        dec.buf_words  = SBC_BUF_256;
        dec.blk_chans  = SBC_BLK_32;
        dec.first_chan = base_32;
      end
      SBC_C256_ALL: begin dec.buf_words = SBC_BUF_256; dec.blk_chans = SBC_BLK_64; end
      // Any other code is undefined for this decoder.
      default:      begin dec.code_ok = 1'b0; end
    endcase
  end
endmodule : sbc_code_decode
`default_nettype wire

// ---- hw/sbc_fill_addr.sv ----
// Buffer write address and channel sequencer for the active setting.
`timescale 1ns/10ps
`default_nettype none
module sbc_fill_addr
  import sbc_pkg::*;
#(
  parameter int AW = 10  // Address width of the sample buffer.
)(
  input  wire logic          sys_clk,     // System clock.
  input  wire logic          sys_rst,     // Asynchronous reset, active high.
  sbc_cfg_if.snk             cfg,         // Active setting.
  input  wire logic          sample_stb,  // One sample written this cycle.
  input  wire logic          restart,     // New setting taken; start over.
  output logic [AW-1:0]      wr_addr,     // Buffer word for the next sample.
  output logic [5:0]         scan_chan,   // Channel for the next sample.
  output logic               buf_wrap     // Pulse: buffer end reached.
);
  // Wrap points of address and channel.
  wire          addr_last = ({{(11-AW){1'b0}}, wr_addr} == (cfg.buf_words - 11'h001));
  wire [5:0]    blk_last  = 6'(cfg.blk_chans - 7'h01);
  wire [5:0]    chan_off  = 6'(scan_chan - cfg.first_chan);
  wire          chan_last = (chan_off == blk_last);

  // Address counts up and returns to zero after the buffer length.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wr_addr <= '0;
    else if (restart)
      wr_addr <= '0;
    else if (sample_stb)
      wr_addr <= addr_last ? '0 : AW'(wr_addr + 1'b1);
  end

  // Channel steps through the block and restarts at its first channel.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      scan_chan <= 6'h00;
    else if (restart)
      scan_chan <= cfg.first_chan;
    else if (sample_stb)
      scan_chan <= chan_last ? cfg.first_chan : 6'(scan_chan + 6'h01);
  end

  // Wrap flag marks the sample that filled the last buffer word.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      buf_wrap <= 1'b0;
    else
      buf_wrap <= sample_stb && addr_last && !restart;
  end

  // After the last word the address returns to zero.
  property p_addr_wraps;
    @(posedge sys_clk) disable iff (sys_rst)
      (sample_stb && !restart && addr_last) |=> (wr_addr == '0) && buf_wrap;
  endproperty
  a_addr_wraps: assert property (p_addr_wraps) else $error("address did not wrap");
endmodule : sbc_fill_addr
`default_nettype wire

// ---- hw/sbc_top.sv ----
// Scan configuration register, decoder and buffer fill sequencing.
//
// Contract
// - Groups past fitted channels invalid on smaller builds.
// - Code 00111: 64 words, single channel bits 5:0.
// - Code 01000: 64 words, eight-channel group bits 2:0.
// - Code 01001: 64 words, sixteen-channel group bits 2:1.
// - Code 01010: 64 words, 32-channel half by bit 2.
// - Code 01011: 64 words, all 64 channels.
// - Code 01100: 128 words, single channel bits 5:0.
// - Code 01101: 128 words, eight-channel group bits 2:0.
// - Code 01110: 128 words, sixteen-channel group bits 2:1.
// - Code 01111: 128 words, 32-channel half by bit 2.
// - Code 10000: 128 words, all 64 channels.
// - Code 10001: 256 words, single channel bits 5:0.
// - Code 10010: 256 words, eight-channel group bits 2:0.
// - Code 10011: 256 words, sixteen-channel group bits 2:1.
// - Code 10100: 256 words, 32-channel half by bit 2.
// - Code 10101: 256 words, all 64 channels.
`timescale 1ns/10ps
`default_nettype none
module sbc_top
  import sbc_pkg::*;
#(
  parameter int CHANNELS = SBC_CHANNELS,  // Channels fitted: 64, 32 or 16.
  parameter int AW       = 10             // Sample buffer address width.
)(
  input  wire logic          sys_clk,     // System clock, 125 MHz.
  input  wire logic          sys_rst,     // Asynchronous reset, active high.
  input  wire logic [15:0]   reg_addr,    // Register byte offset.
  input  wire logic          reg_wr,      // Write strobe, one cycle.
  input  wire logic          reg_rd,      // Read strobe, one cycle.
  input  wire logic [15:0]   reg_wdata,   // Write data.
  output logic [15:0]        reg_rdata,   // Read data, valid after a read.
  input  wire logic          sample_stb,  // One converted sample stored.
  output logic [10:0]        buf_words,   // Active buffer length in words.
  output logic [6:0]         blk_chans,   // Active block length in channels.
  output logic [5:0]         first_chan,  // First channel of active group.
  output logic               irq_src,     // Interrupt source bit.
  output logic [1:0]         gain_mode,   // Gain mode field.
  output logic [1:0]         scan_mode,   // Scan mode field.
  output logic [AW-1:0]      wr_addr,     // Buffer word for next sample.
  output logic [5:0]         scan_chan,   // Channel for next sample.
  output logic               buf_wrap,    // Pulse: buffer end reached.
  output logic               cfg_reject   // Pulse: last write was refused.
);
  // Decoded view of the word on the write port.
  sbc_cfg_if dec_if ();
  // Active setting as seen by the sequencer.
  sbc_cfg_if act_if ();

  // Stored configuration word and decoded setting.
  logic [15:0] cfg_word_q;   // Last accepted word.
  logic [10:0] buf_words_q;  // Active buffer length.
  logic [6:0]  blk_chans_q;  // Active block length.
  logic [5:0]  first_chan_q; // Active first channel.
  logic        restart_q;    // Pulse: new setting in force.
  logic        reject_q;     // Pulse: write refused.
  logic [15:0] rdata_q;      // Read data register.
  logic        fits_build;   // Offered group fits this build.

  // Address decode and acceptance of a write.
  wire       cfg_hit  = (reg_addr == SBC_CFG_OFFSET);
  wire       cfg_wr   = reg_wr && cfg_hit;
  wire       word_ok  = dec_if.code_ok && fits_build;
  wire       take     = cfg_wr && word_ok;
  wire       refuse   = cfg_wr && !word_ok;
  wire [4:0] wr_code  = reg_wdata[SBC_CODE_MSB:SBC_CODE_LSB];

  // Decoder sees the offered word directly.
  sbc_code_decode #(
    .CHANNELS   (CHANNELS)
  ) u_decode (
    .cfg_word   (reg_wdata),
    .dec        (dec_if),
    .fits_build (fits_build)
  );

  // Active setting feeds the sequencer.
  assign act_if.buf_words  = buf_words_q;
  assign act_if.blk_chans  = blk_chans_q;
  assign act_if.first_chan = first_chan_q;
  assign act_if.code_ok    = 1'b1;

  // Sequencer for buffer address and scan channel.
  sbc_fill_addr #(
    .AW         (AW)
  ) u_fill (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .cfg        (act_if),
    .sample_stb (sample_stb),
    .restart    (restart_q),
    .wr_addr    (wr_addr),
    .scan_chan  (scan_chan),
    .buf_wrap   (buf_wrap)
  );

  // Accepted word is stored; others leave the register untouched.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cfg_word_q <= SBC_CFG_RESET;
    else if (take)
      cfg_word_q <= reg_wdata;
  end

  // Decoded setting follows only accepted words.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      buf_words_q  <= SBC_BUF_64;
      blk_chans_q  <= SBC_BLK_1;
      first_chan_q <= 6'h00;
    end
    else if (take)
    begin
      buf_words_q  <= dec_if.buf_words;
      blk_chans_q  <= dec_if.blk_chans;
      first_chan_q <= dec_if.first_chan;
    end
  end

  // One-cycle pulses for a taken and a refused write.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      restart_q <= 1'b0;
      reject_q  <= 1'b0;
    end
    else
    begin
      restart_q <= take;
      reject_q  <= refuse;
    end
  end

  // Read returns the stored word at the register offset, zero elsewhere.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 16'h0000;
    else if (reg_rd)
      rdata_q <= cfg_hit ? cfg_word_q : 16'h0000;
  end

  // Outputs straight from the registers.
  assign reg_rdata  = rdata_q;
  assign buf_words  = buf_words_q;
  assign blk_chans  = blk_chans_q;
  assign first_chan = first_chan_q;
  assign cfg_reject = reject_q;
  // Interrupt, gain and scan fields pass on as the host set them.
  assign irq_src    = cfg_word_q[SBC_IRQ_BIT];
  assign gain_mode  = cfg_word_q[SBC_GAIN_MSB:SBC_GAIN_LSB];
  assign scan_mode  = cfg_word_q[SBC_SCAN_MSB:SBC_SCAN_LSB];

  // A taken write appears on read-back after it lands.
  property p_store;
    @(posedge sys_clk) disable iff (sys_rst)
      take ##1 !reg_wr ##1 (reg_rd && cfg_hit && !reg_wr)
        |=> (reg_rdata == $past(reg_wdata, 3));
  endproperty
  a_store: assert property (p_store) else $error("stored word wrong");

  // A single channel past the fitted channels is never taken with the 64-word single-channel code.
  property p_build;
    @(posedge sys_clk) disable iff (sys_rst)
      (cfg_wr && dec_if.code_ok && (32'(reg_wdata[5:0]) >= CHANNELS)
       && (wr_code == SBC_C64_ONE)) |=> cfg_reject && $stable(buf_words);
  endproperty
  a_build: assert property (p_build) else $error("channel past build taken");

  // Single channel, 64 words.
  property p_c64_one;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C64_ONE) |=> (buf_words == 11'h040)
        && (blk_chans == 7'h01) && (first_chan == $past(reg_wdata[5:0]));
  endproperty
  a_c64_one: assert property (p_c64_one) else $error("64 single wrong");

  // Group of eight, 64 words.
  property p_c64_g8;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C64_G8) |=> (buf_words == 11'h040)
        && (blk_chans == 7'h08) && (first_chan == {$past(reg_wdata[2:0]), 3'b000});
  endproperty
  a_c64_g8: assert property (p_c64_g8) else $error("64 group of 8 wrong");

  // Group of sixteen, 64 words, bit 0 ignored.
  property p_c64_g16;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C64_G16) |=> (buf_words == 11'h040)
        && (blk_chans == 7'h10) && (first_chan == {$past(reg_wdata[2:1]), 4'h0});
  endproperty
  a_c64_g16: assert property (p_c64_g16) else $error("64 group of 16 wrong");

  // Half of the channels, 64 words.
  property p_c64_g32;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C64_G32) |=> (buf_words == 11'h040) && (blk_chans == 7'h20)
        && (first_chan == ($past(reg_wdata[2]) ? 6'h20 : 6'h00));
  endproperty
  a_c64_g32: assert property (p_c64_g32) else $error("64 group of 32 wrong");

  // All channels, 64 words.
  property p_c64_all;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C64_ALL) |=> (buf_words == 11'h040)
        && (blk_chans == 7'h40) && (first_chan == 6'h00);
  endproperty
  a_c64_all: assert property (p_c64_all) else $error("64 all wrong");

  // Single channel, 128 words.
  property p_c128_one;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C128_ONE) |=> (buf_words == 11'h080)
        && (blk_chans == 7'h01) && (first_chan == $past(reg_wdata[5:0]));
  endproperty
  a_c128_one: assert property (p_c128_one) else $error("128 single wrong");

  // Group of eight, 128 words.
  property p_c128_g8;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C128_G8) |=> (buf_words == 11'h080)
        && (blk_chans == 7'h08) && (first_chan == {$past(reg_wdata[2:0]), 3'b000});
  endproperty
  a_c128_g8: assert property (p_c128_g8) else $error("128 group of 8 wrong");

  // Group of sixteen, 128 words.
  property p_c128_g16;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C128_G16) |=> (buf_words == 11'h080)
        && (blk_chans == 7'h10) && (first_chan == {$past(reg_wdata[2:1]), 4'h0});
  endproperty
  a_c128_g16: assert property (p_c128_g16) else $error("128 group of 16 wrong");

  // Half of the channels, 128 words.
  property p_c128_g32;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C128_G32) |=> (buf_words == 11'h080) && (blk_chans == 7'h20)
        && (first_chan == ($past(reg_wdata[2]) ? 6'h20 : 6'h00));
  endproperty
  a_c128_g32: assert property (p_c128_g32) else $error("128 group of 32 wrong");

  // All channels, 128 words.
  property p_c128_all;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C128_ALL) |=> (buf_words == 11'h080)
        && (blk_chans == 7'h40) && (first_chan == 6'h00);
  endproperty
  a_c128_all: assert property (p_c128_all) else $error("128 all wrong");

  // Single channel, 256 words.
  property p_c256_one;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C256_ONE) |=> (buf_words == 11'h100)
        && (blk_chans == 7'h01) && (first_chan == $past(reg_wdata[5:0]));
  endproperty
  a_c256_one: assert property (p_c256_one) else $error("256 single wrong");

  // Group of eight, 256 words.
  property p_c256_g8;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C256_G8) |=> (buf_words == 11'h100)
        && (blk_chans == 7'h08) && (first_chan == {$past(reg_wdata[2:0]), 3'b000});
  endproperty
  a_c256_g8: assert property (p_c256_g8) else $error("256 group of 8 wrong");

  // Group of sixteen, 256 words.
  property p_c256_g16;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C256_G16) |=> (buf_words == 11'h100)
        && (blk_chans == 7'h10) && (first_chan == {$past(reg_wdata[2:1]), 4'h0});
  endproperty
  a_c256_g16: assert property (p_c256_g16) else $error("256 group of 16 wrong");

  // Half of the channels, 256 words.
  property p_c256_g32;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C256_G32) |=> (buf_words == 11'h100)
        && (blk_chans == 7'h20) && (first_chan == ($past(reg_wdata[2]) ? 6'h20 : 6'h00));
  endproperty
  a_c256_g32: assert property (p_c256_g32) else $error("256 group of 32 wrong");

  // All channels, 256 words.
  property p_c256_all;
    @(posedge sys_clk) disable iff (sys_rst)
      (take && wr_code == SBC_C256_ALL) |=> (buf_words == 11'h100)
        && (blk_chans == 7'h40) && (first_chan == 6'h00);
  endproperty
  a_c256_all: assert property (p_c256_all) else $error("256 all wrong");

  // Address restarts at zero and channel at the first channel after a new setting.
  property p_fill;
    @(posedge sys_clk) disable iff (sys_rst)
      restart_q |=> (wr_addr == '0) && (scan_chan == $past(first_chan));
  endproperty
  a_fill: assert property (p_fill) else $error("fill did not restart");

  // Undefined codes change nothing and raise the refusal pulse.
  property p_undef;
    @(posedge sys_clk) disable iff (sys_rst)
      (cfg_wr && !dec_if.code_ok) |=> cfg_reject && !restart_q
        && $stable(cfg_word_q) && $stable(buf_words) && $stable(first_chan);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined code changed setting");
endmodule : sbc_top
`default_nettype wire

// ---- include/sbc_cfg_if.sv ----
// Carrier for one decoded buffer and block setting.
`timescale 1ns/10ps
`default_nettype none
interface sbc_cfg_if;
  logic [10:0] buf_words;   // Buffer length in words.
  logic [6:0]  blk_chans;   // Channels per scan block.
  logic [5:0]  first_chan;  // First channel of the active group.
  logic        code_ok;     // Upper code names a known combination.
  // Producer side.
  modport src (output buf_words, output blk_chans, output first_chan, output code_ok);
  // Consumer side.
  modport snk (input buf_words, input blk_chans, input first_chan, input code_ok);
endinterface : sbc_cfg_if
`default_nettype wire

// ---- include/sbc_pkg.sv ----
// Constants shared by the scan buffer configuration decoder.
package sbc_pkg;
  // Byte offset of the scan configuration register.
  localparam logic [15:0] SBC_CFG_OFFSET = 16'h0004;
  // Field positions inside the configuration word.
  localparam int SBC_CODE_MSB = 15;
  localparam int SBC_CODE_LSB = 11;
  localparam int SBC_IRQ_BIT  = 10;
  localparam int SBC_GAIN_MSB = 9;
  localparam int SBC_GAIN_LSB = 8;
  localparam int SBC_SCAN_MSB = 7;
  localparam int SBC_SCAN_LSB = 6;
  // Word after reset: 64-word buffer from single channel 0.
  localparam logic [15:0] SBC_CFG_RESET = 16'h3800;
  // Buffer and block codes held in bits 15:11.
  localparam logic [4:0] SBC_C64_ONE  = 5'h07;
  localparam logic [4:0] SBC_C64_G8   = 5'h08;
  localparam logic [4:0] SBC_C64_G16  = 5'h09;
  localparam logic [4:0] SBC_C64_G32  = 5'h0A;
  localparam logic [4:0] SBC_C64_ALL  = 5'h0B;
  localparam logic [4:0] SBC_C128_ONE = 5'h0C;
  localparam logic [4:0] SBC_C128_G8  = 5'h0D;
  localparam logic [4:0] SBC_C128_G16 = 5'h0E;
  localparam logic [4:0] SBC_C128_G32 = 5'h0F;
  localparam logic [4:0] SBC_C128_ALL = 5'h10;
  localparam logic [4:0] SBC_C256_ONE = 5'h11;
  localparam logic [4:0] SBC_C256_G8  = 5'h12;
  localparam logic [4:0] SBC_C256_G16 = 5'h13;
  localparam logic [4:0] SBC_C256_G32 = 5'h14;
  localparam logic [4:0] SBC_C256_ALL = 5'h15;
  // Buffer lengths in words.
  localparam logic [10:0] SBC_BUF_64  = 11'h040;
  localparam logic [10:0] SBC_BUF_128 = 11'h080;
  localparam logic [10:0] SBC_BUF_256 = 11'h100;
  // Block lengths in channels.
  localparam logic [6:0] SBC_BLK_1  = 7'h01;
  localparam logic [6:0] SBC_BLK_8  = 7'h08;
  localparam logic [6:0] SBC_BLK_16 = 7'h10;
  localparam logic [6:0] SBC_BLK_32 = 7'h20;
  localparam logic [6:0] SBC_BLK_64 = 7'h40;
  // Channel count of the full board build.
  localparam int SBC_CHANNELS = 64;
endpackage : sbc_pkg

// ---- tb/sbc_host_model.sv ----
// Host model that writes and reads the configuration register.
`timescale 1ns/10ps
`default_nettype none
module sbc_host_model (
  input  wire logic        sys_clk,   // System clock.
  output var  logic [15:0] reg_addr,  // Register byte offset.
  output var  logic        reg_wr,    // Write strobe.
  output var  logic        reg_rd,    // Read strobe.
  output var  logic [15:0] reg_wdata  // Write data.
);
  // The bus starts idle with a data pattern that means nothing.
  initial
  begin
    reg_addr  = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'hA5A5;
  end
  // One write after a gap; released lines show the inverse so stale data never passes.
  task automatic wr(input logic [15:0] addr, input logic [15:0] data, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~data;
    reg_addr  <= ~addr;
  endtask : wr
  // One read after a gap; the answer is taken by the bench monitor.
  task automatic rd(input logic [15:0] addr, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~addr;
  endtask : rd
endmodule : sbc_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the scan configuration decoder.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sbc_pkg::*;
  typedef struct {logic [15:0] rd; logic [10:0] bw; logic [6:0] bc; logic [5:0] fc;} sbc_exp_type;
  localparam logic [6:0] BLK_TAB [5] = '{SBC_BLK_1, SBC_BLK_8, SBC_BLK_16, SBC_BLK_32, SBC_BLK_64};
  logic        sys_clk = 1'b0;     // Bench clock.
  logic        sys_rst = 1'b1;     // Reset, held at start.
  logic        sample_stb = 1'b0;  // Sample strobe.
  logic        rd_d = 1'b0;        // A read was taken at the last edge.
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, irq_src, buf_wrap, cfg_reject;
  logic [10:0] buf_words;
  logic [6:0]  blk_chans;
  logic [5:0]  first_chan, scan_chan;
  logic [1:0]  gain_mode, scan_mode;
  logic [9:0]  wr_addr;
  logic        rej16;              // Refusal pulse of the 16-channel build.
  int          n_errors = 0;       // Mismatches.
  int          n_compared = 0;     // Comparisons.
  int unsigned seed;               // Seeding result.
  sbc_exp_type exp_q[$];           // Expected read results.
  sbc_exp_type cur;                // Setting the design should hold.
  sbc_exp_type got;                // Entry taken by the monitor.
  // Clock at 125 MHz.
  always #4 sys_clk = ~sys_clk;
  sbc_host_model host (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
  sbc_top uut (.sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .sample_stb, .buf_words, .blk_chans, .first_chan, .irq_src, .gain_mode, .scan_mode,
    .wr_addr, .scan_chan, .buf_wrap, .cfg_reject);
  // Second copy built for 16 channels, so that groups past its build are refused.
  sbc_top #(.CHANNELS(16)) uut16 (.sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata(), .sample_stb, .buf_words(), .blk_chans(), .first_chan(), .irq_src(),
    .gain_mode(), .scan_mode(), .wr_addr(), .scan_chan(), .buf_wrap(), .cfg_reject(rej16));
  // Compares one value and counts it.
  task automatic check(input string name, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (e !== s)
    begin
      $display("unexpected %s expected %h seen %h", name, e, s);
      n_errors++;
    end
  endtask : check
  // Works out the setting a word should give; unknown codes keep the old one.
  function automatic sbc_exp_type decode(input logic [15:0] w);
    sbc_exp_type e;
    int k;
    e = cur;
    k = int'(w[15:11]) - 7;
    if (k >= 0 && k < 15)
    begin
      e.rd = w;
      e.bw = (k < 5) ? SBC_BUF_64 : (k < 10) ? SBC_BUF_128 : SBC_BUF_256;
      e.bc = BLK_TAB[k % 5];
      e.fc = (k % 5 == 0) ? w[5:0] : 6'({1'b0, w[2:0], 3'h0} & ~(e.bc - 7'h01));
    end
    return e;
  endfunction : decode
  // Notes what a read should return, then reads; other offsets read as zero.
  task automatic probe(input logic [15:0] a);
    sbc_exp_type e;
    e = cur;
    if (a != 16'h0004)
      e.rd = 16'h0000;
    exp_q.push_back(e);
    host.rd(a, $urandom_range(2));
  endtask : probe
  // Writes a configuration word, checks the refusal pulse, then reads back.
  task automatic put(input logic [15:0] w);
    sbc_exp_type e;
    e = decode(w);
    host.wr(16'h0004, w, $urandom_range(2));
    #1;
    check("reject flag", 16'(e.rd !== w), 16'(cfg_reject));
    check("small build reject", 16'(e.rd !== w || int'(e.fc) + int'(e.bc) > 16),
      16'(rej16));
    cur = e;
    probe(16'h0004);
  endtask : put
  // Streams one full buffer of samples and follows address, channel and wrap.
  task automatic fill();
    int i;
    @(posedge sys_clk);
    sample_stb <= 1'b1;
    for (i = 1; i <= int'(cur.bw); i++)
    begin
      @(posedge sys_clk);
      if (i == int'(cur.bw))
        sample_stb <= 1'b0;
      #1;
      check("write address", 16'(i % int'(cur.bw)), 16'(wr_addr));
      check("scan channel", 16'(int'(cur.fc) + i % int'(cur.bc)), 16'(scan_chan));
      check("wrap pulse", 16'(i == int'(cur.bw)), 16'(buf_wrap));
    end
  endtask : fill
  // Flags each read that the design took at the last edge.
  always @(posedge sys_clk)
    rd_d <= reg_rd && !sys_rst;
  // Compares each read result with the oldest note.
  always @(negedge sys_clk)
  begin
    if (rd_d)
    begin
      got = exp_q.pop_front();
      check("read data", got.rd, reg_rdata);
      check("buffer words", 16'(got.bw), 16'(buf_words));
      check("block channels", 16'(got.bc), 16'(blk_chans));
      check("first channel", 16'(got.fc), 16'(first_chan));
      check("mode fields", 16'(cur.rd[10:6]), 16'({irq_src, gain_mode, scan_mode}));
    end
  end
  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // Cuts a hang short far beyond the normal run length.
  initial
  begin
    #400000;
    n_errors++;
    summarize();
  end
  // Resets the design and works through the tests.
  initial
  begin
    int c;
    seed = $urandom(32'h418629F7);
    cur = '{SBC_CFG_RESET, SBC_BUF_64, SBC_BLK_1, 6'h00};
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    probe(16'h0004);
    $display("test reset done");
    for (c = 7; c < 22; c++)
    begin
      put({5'(c), 11'($urandom)});
      put({5'(c), 11'($urandom)});
    end
    $display("test code sweep done");
    for (c = 0; c < 6; c++)
      put({5'(c < 3 ? $urandom_range(6) : $urandom_range(31, 22)), 11'($urandom)});
    $display("test undefined codes done");
    host.wr(16'h0006, 16'($urandom), 0);
    probe(16'h0006);
    probe(16'h0004);
    $display("test other offset done");
    put({SBC_C128_G16, 11'($urandom)});
    fill();
    put({SBC_C64_ALL, 11'($urandom)});
    fill();
    put({SBC_C256_ONE, 11'($urandom)});
    fill();
    $display("test buffer fill done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
